// ==== hw/wbm_bank.sv ====
// Watchdog and transceiver mode control register bank
`timescale 1ns/1ps
`include "wbm_cfg.svh"
// What this block does
// - Watchdog writes with odd parity over eight bits are dropped and flag failure.
// - The checksum bit always reads back as zero.
// - Bit 6 set suspends the watchdog during stop mode.
// - Bit 5 selects window watchdog instead of pure timeout.
// - Bit 4 lets a bus wake in stop start the watchdog.
// - Bit 3 stops resets after three consecutive watchdog resets.
// - Period field codes 0 to 5 pick 10 to 500 ms; six and seven reserved.
// - LIN flash bit disables slope control for fast baud rates.
// - Slope select bit picks low-slope LIN signalling.
// - Transmit timeout bit enables stuck-dominant transmit detection.
// - First LIN mode field bits 4:3: off, wake, receive-only, normal.
// - CAN normal runs as wake capable in stop or sleep, bits kept.
// - LIN normal runs as wake capable in stop or sleep, bits kept.
// - Second LIN mode field bits 1:0 in second bus register.
// - Reserved bits of both bus registers read as zero.
// - Frame bit 7 chooses read (0) or write of the data byte (1).
// - Control bits change only by host write or hardware update.
module wbm_bank (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic csN,
	input wire logic sclk,
	input wire logic mosi,
	output logic misoO,
	output logic misoOeN,
	input wire logic [1:0] sysMode,
	input wire logic hwUpdate,
	input wire logic [7:0] hwWdogValue,
	input wire logic [7:0] hwBus1Value,
	input wire logic [7:0] hwBus2Value,
	input wire logic watchdogResetEvent,
	input wire logic watchdogTriggerGood,
	output logic spiFail,
	input wire logic spiFailClear,
	output logic watchdogRun,
	output logic windowStyleSelect,
	output logic startOnBusWake,
	output logic resetLimitEn,
	output logic resetAllowed,
	output logic [2:0] guardPeriodSelect,
	output logic periodReserved,
	output logic linFlash,
	output logic slowEdgeSelect,
	output logic transmitStuckGuardEn,
	output logic [1:0] canModeActive,
	output logic [1:0] firstLinModeActive,
	output logic [1:0] secondLinModeActive
);
	wbm_ctl_if ctl ();
	logic [7:0] wdog_reg, bus1_reg, bus2_reg;
	logic [1:0] rstCount_reg;
	logic spiFail_reg;
	logic [6:0] addr;
	logic [6:0] rdAddr;
	logic isWrite, parityOk, lowPower;
	logic [7:0] wrData;

	// ****************************************************************
	// Serial front end
	// ****************************************************************
	wbm_spi_rx rx (
		.clk(clk),
		.reset(reset),
		.clkEn(clkEn),
		.csN(csN),
		.sclk(sclk),
		.mosi(mosi),
		.misoO(misoO),
		.misoOeN(misoOeN),
		.ctl(ctl)
	);

	// Frame layout: address low bits, access bit, then data byte
	assign addr = ctl.frameWord[6:0];
	assign isWrite = ctl.frameWord[`WBM_BIT_WRITE];
	assign wrData = ctl.frameWord[15:8];
	assign parityOk = ~^wrData;

	// ****************************************************************
	// Read path
	// ****************************************************************
	// Mid-frame the control byte sits in the upper half of the shifter
	assign rdAddr = ctl.frameWord[14:8];
	always_comb begin
		if (rdAddr == `WBM_ADDR_WDOG)
			ctl.readData = {1'b0, wdog_reg[6:0]};
		else if (rdAddr == `WBM_ADDR_BUS1)
			ctl.readData = {bus1_reg[7:3], 1'b0, bus1_reg[1:0]};
		else if (rdAddr == `WBM_ADDR_BUS2)
			ctl.readData = {6'h00, bus2_reg[1:0]};
		else
			ctl.readData = 8'h00;
	end

	// ****************************************************************
	// Watchdog control register
	// ****************************************************************
	// Host write wins; hardware reaches only its own modifiable fields
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			wdog_reg <= `WBM_RST_WDOG;
		else if (clkEn) begin
			if (ctl.frameDone && isWrite && addr == `WBM_ADDR_WDOG) begin
				if (parityOk)
					wdog_reg <= {1'b0, wrData[6:0]};
			end else if (hwUpdate)
				wdog_reg <= {1'b0, hwWdogValue[`WBM_BIT_STOPOFF],
					wdog_reg[`WBM_BIT_WINDOW], hwWdogValue[`WBM_BIT_BUSWAKE],
					wdog_reg[`WBM_BIT_MAXRST], hwWdogValue[2:0]};
		end
	end

	// Failure flag; a new failure beats a clear in the same cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			spiFail_reg <= 1'b0;
		else if (clkEn) begin
			if (ctl.frameDone && isWrite && addr == `WBM_ADDR_WDOG &&
				!parityOk)
				spiFail_reg <= 1'b1;
			else if (spiFailClear)
				spiFail_reg <= 1'b0;
		end
	end
	assign spiFail = spiFail_reg;

	// ****************************************************************
	// Bus mode registers
	// ****************************************************************
	// Reserved bits are never stored, so they cannot read back
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bus1_reg <= `WBM_RST_BUS1;
			bus2_reg <= `WBM_RST_BUS2;
		end else if (clkEn) begin
			if (ctl.frameDone && isWrite && addr == `WBM_ADDR_BUS1)
				bus1_reg <= {wrData[7:3], 1'b0, wrData[1:0]};
			else if (hwUpdate)
				bus1_reg <= {bus1_reg[7:5], hwBus1Value[4:3], 1'b0,
					hwBus1Value[1:0]};
			if (ctl.frameDone && isWrite && addr == `WBM_ADDR_BUS2)
				bus2_reg <= {6'h00, wrData[1:0]};
			else if (hwUpdate)
				bus2_reg <= {6'h00, hwBus2Value[1:0]};
		end
	end

	// ****************************************************************
	// Reset repetition limit
	// ****************************************************************
	// Counts consecutive watchdog resets; a good trigger restarts it
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			rstCount_reg <= 2'h0;
		else if (clkEn) begin
			if (watchdogResetEvent && rstCount_reg != `WBM_RST_LIMIT)
				rstCount_reg <= rstCount_reg + 2'h1;
			else if (watchdogTriggerGood)
				rstCount_reg <= 2'h0;
		end
	end
	assign resetLimitEn = wdog_reg[`WBM_BIT_MAXRST];
	assign resetAllowed = !resetLimitEn ||
		rstCount_reg != `WBM_RST_LIMIT;

	// ****************************************************************
	// Watchdog controls
	// ****************************************************************
	assign lowPower = (sysMode == wbm_pkg::WBM_SYS_STOP) ||
		(sysMode == wbm_pkg::WBM_SYS_SLEEP);
	// Suspension only applies in stop mode
	assign watchdogRun = !(sysMode == wbm_pkg::WBM_SYS_STOP &&
		wdog_reg[`WBM_BIT_STOPOFF]);
	assign windowStyleSelect = wdog_reg[`WBM_BIT_WINDOW];
	assign startOnBusWake = wdog_reg[`WBM_BIT_BUSWAKE];
	assign guardPeriodSelect = wdog_reg[2:0];
	// Code six has no period, so it is treated like seven
	assign periodReserved = wdog_reg[2:0] == `WBM_PER_RSVD6 ||
		wdog_reg[2:0] == `WBM_PER_RSVD7;

	// ****************************************************************
	// Transceiver controls
	// ****************************************************************
	assign linFlash = bus1_reg[`WBM_BIT_FLASH];
	assign slowEdgeSelect = bus1_reg[`WBM_BIT_SLOW];
	assign transmitStuckGuardEn = bus1_reg[`WBM_BIT_TXGUARD];

	// Normal falls back to wake capable in low power; others pass as set
	function automatic logic [1:0] effMode(input logic [1:0] prog,
		input logic lp);
		if (lp && prog == wbm_pkg::WBM_XCVR_NORMAL)
			effMode = wbm_pkg::WBM_XCVR_WAKE;
		else
			effMode = prog;
	endfunction

	assign canModeActive =
		effMode(bus1_reg[1:0], lowPower);
	assign firstLinModeActive =
		effMode(bus1_reg[4:3], lowPower);
	assign secondLinModeActive =
		effMode(bus2_reg[1:0], lowPower);
endmodule // wbm_bank

// ==== hw/wbm_cfg.svh ====
// Register offsets, field positions and reset values of the bus mode bank
`ifndef WBM_CFG_SVH
`define WBM_CFG_SVH

// ****************************************************************
// Register addresses (7-bit)
// ****************************************************************
`define WBM_ADDR_WDOG 7'h03
`define WBM_ADDR_BUS1 7'h04
`define WBM_ADDR_BUS2 7'h05

// ****************************************************************
// Reset values
// ****************************************************************
`define WBM_RST_WDOG 8'h14
`define WBM_RST_BUS1 8'h20
`define WBM_RST_BUS2 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define WBM_BIT_CKSUM 7
`define WBM_BIT_STOPOFF 6
`define WBM_BIT_WINDOW 5
`define WBM_BIT_BUSWAKE 4
`define WBM_BIT_MAXRST 3
`define WBM_BIT_FLASH 7
`define WBM_BIT_SLOW 6
`define WBM_BIT_TXGUARD 5
`define WBM_BIT_WRITE 7

// ****************************************************************
// Frame and mode codes
// ****************************************************************
`define WBM_FRAME_BITS 5'h10
`define WBM_FRAME_LAST 5'h0F
`define WBM_CTRL_BITS 5'h08
`define WBM_PER_RSVD6 3'h6
`define WBM_PER_RSVD7 3'h7
`define WBM_RST_LIMIT 2'h3

`endif

// ==== hw/wbm_pkg.sv ====
// Types shared by the bus mode register bank
package wbm_pkg;
	// Transceiver operating modes
	typedef enum logic [1:0] {
		WBM_XCVR_OFF = 2'h0,
		WBM_XCVR_WAKE = 2'h1,
		WBM_XCVR_RXONLY = 2'h2,
		WBM_XCVR_NORMAL = 2'h3
	} wbm_xcvr_t;

	// System operating modes
	typedef enum logic [1:0] {
		WBM_SYS_NORMAL = 2'h0,
		WBM_SYS_SLEEP = 2'h1,
		WBM_SYS_STOP = 2'h2,
		WBM_SYS_RESET = 2'h3
	} wbm_sys_t;

	// Serial frame receiver states, one bit per step except done to idle
	typedef enum logic [1:0] {
		WBM_SER_IDLE = 2'h0,
		WBM_SER_SHIFT = 2'h1,
		WBM_SER_DONE = 2'h3
	} wbm_ser_t;
endpackage

// ==== hw/wbm_ctl_if.sv ====
// Carrier between frame receiver and register bank
`timescale 1ns/1ps
interface wbm_ctl_if;
	logic frameDone;
	logic [15:0] frameWord;
	logic [7:0] readData;
	modport rx (output frameDone, output frameWord, input readData);
	modport bank (input frameDone, input frameWord, output readData);
endinterface

// ==== hw/wbm_spi_rx.sv ====
// Serial frame receiver and read-data shifter for the register bank
`timescale 1ns/1ps
`include "wbm_cfg.svh"
module wbm_spi_rx (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic csN,
	input wire logic sclk,
	input wire logic mosi,
	output logic misoO,
	output logic misoOeN,
	wbm_ctl_if.rx ctl
);
	logic [2:0] csSync, sclkSync, mosiSync;
	wbm_pkg::wbm_ser_t state_reg;
	logic [4:0] bitCnt_reg;
	logic [15:0] shift_reg;
	logic [7:0] outShift_reg;
	logic sclkRise, sclkFall;

	// Two stages to cross in; third stage only for edge detect
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			csSync <= 3'h7;
			sclkSync <= 3'h0;
			mosiSync <= 3'h0;
		end else if (clkEn) begin
			csSync <= {csSync[1:0], csN};
			sclkSync <= {sclkSync[1:0], sclk};
			mosiSync <= {mosiSync[1:0], mosi};
		end
	end

	assign sclkRise = sclkSync[1] & ~sclkSync[2];
	assign sclkFall = ~sclkSync[1] & sclkSync[2];

	// Frame state: bit 0 first, complete at 16 bits and chip deselect
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= wbm_pkg::WBM_SER_IDLE;
			bitCnt_reg <= 5'h00;
			shift_reg <= 16'h0000;
		end else if (clkEn) begin
			case (state_reg)
				wbm_pkg::WBM_SER_IDLE: begin
					bitCnt_reg <= 5'h00;
					if (!csSync[1])
						state_reg <= wbm_pkg::WBM_SER_SHIFT;
				end
				wbm_pkg::WBM_SER_SHIFT: begin
					if (sclkRise && bitCnt_reg < `WBM_FRAME_BITS)
						shift_reg <= {mosiSync[1], shift_reg[15:1]};
					// Count one past a full frame so a long one is refused
					if (sclkRise && bitCnt_reg <= `WBM_FRAME_BITS)
						bitCnt_reg <= bitCnt_reg + 5'h01;
					// Short or long frames are dropped
					if (csSync[1])
						state_reg <= (bitCnt_reg == `WBM_FRAME_BITS) ?
							wbm_pkg::WBM_SER_DONE : wbm_pkg::WBM_SER_IDLE;
				end
				wbm_pkg::WBM_SER_DONE: state_reg <= wbm_pkg::WBM_SER_IDLE;
				default: state_reg <= wbm_pkg::WBM_SER_IDLE;
			endcase
		end
	end

	assign ctl.frameDone = clkEn && (state_reg == wbm_pkg::WBM_SER_DONE);
	assign ctl.frameWord = shift_reg;

	// Read data goes out bit 0 first once the control byte is complete
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			outShift_reg <= 8'h00;
			misoO <= 1'b0;
		end else if (clkEn) begin
			if (sclkFall && bitCnt_reg == `WBM_CTRL_BITS) begin
				misoO <= ctl.readData[0];
				outShift_reg <= {1'b0, ctl.readData[7:1]};
			end else if (sclkFall && bitCnt_reg > `WBM_CTRL_BITS) begin
				misoO <= outShift_reg[0];
				outShift_reg <= {1'b0, outShift_reg[7:1]};
			end
		end
	end

	assign misoOeN = csSync[1];
endmodule // wbm_spi_rx

// ==== tb/wbm_bank_assertions.sv ====
// Port checks for the bus mode register bank
`timescale 1ns/1ps
module wbm_bank_assertions (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic csN,
	input wire logic [1:0] sysMode,
	input wire logic watchdogResetEvent,
	input wire logic watchdogTriggerGood,
	input wire logic spiFail,
	input wire logic spiFailClear,
	input wire logic watchdogRun,
	input wire logic resetLimitEn,
	input wire logic resetAllowed,
	input wire logic [2:0] guardPeriodSelect,
	input wire logic periodReserved,
	input wire logic misoOeN,
	input wire logic [1:0] canModeActive,
	input wire logic [1:0] firstLinModeActive,
	input wire logic [1:0] secondLinModeActive
);
	// ****
	// Checks
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Stop and sleep both count as low power
	wire lowPwr = sysMode == 2'h1 || sysMode == 2'h2;
	a_run_outside_stop: assert property (sysMode != 2'h2 |-> watchdogRun)
		else $error("watchdog halted outside stop");
	a_period_flag: assert property (periodReserved == (guardPeriodSelect >= 3'h6))
		else $error("reserved period flag wrong");
	a_can_lowpower: assert property (lowPwr |-> canModeActive != 2'h3)
		else $error("can normal in low power");
	a_lin_lowpower: assert property (lowPwr |-> firstLinModeActive != 2'h3 && secondLinModeActive != 2'h3)
		else $error("lin normal in low power");
	a_fail_sticky: assert property (spiFail && !spiFailClear && clkEn |=> spiFail)
		else $error("failure flag lost");
	// Flag may only rise shortly after a frame ends
	a_fail_source: assert property (!csN [*8] |-> !$rose(spiFail))
		else $error("failure flag rose mid frame");
	a_oe_idle: assert property (csN [*5] |-> misoOeN)
		else $error("data out driven while deselected");
	a_limit_clear: assert property (watchdogTriggerGood && !watchdogResetEvent && clkEn |=> resetAllowed)
		else $error("good trigger did not clear limit");
	a_limit_cause: assert property ($fell(resetAllowed) |-> resetLimitEn && ($past(watchdogResetEvent) || $rose(resetLimitEn)))
		else $error("reset blocked without cause");
	cover property ($rose(spiFail));
	cover property (!resetAllowed);
	cover property (sysMode == 2'h2 && canModeActive == 2'h1);
endmodule // wbm_bank_assertions

// ==== tb/wbm_host.sv ====
// Microcontroller side: sixteen-bit serial master
`timescale 1ns/1ps
module wbm_host (
	input wire logic clk,
	output logic csN,
	output logic sclk,
	output logic mosi,
	input wire logic misoO,
	input wire logic misoOeN
);
	logic lastBit = 1'b0;
	logic line;
	// Idle levels at time zero
	initial begin
		csN = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	// Released line shows inverse of last value, never a lucky match
	always @(misoO or misoOeN)
		if (!misoOeN)
			lastBit = misoO;
	assign line = misoOeN ? ~lastBit : misoO;
	// Frame of n bits, bit 0 first, half period four clocks
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [7:0] rdat);
		rdat = 8'h00;
		@(negedge clk) csN = 1'b0;
		repeat (3) @(negedge clk);
		for (int i = 0; i < n; i++) begin
			mosi = w[i % 16];
			repeat (4) @(negedge clk);
			sclk = 1'b1;
			if (i >= 8 && i < 16)
				rdat = {line, rdat[7:1]};
			repeat (4) @(negedge clk);
			sclk = 1'b0;
		end
		mosi = ~mosi;
		repeat (2) @(negedge clk);
		csN = 1'b1;
		repeat (8) @(negedge clk);
	endtask
endmodule // wbm_host

// ==== tb/tb_top.sv ====
// Self-checking bench of the watchdog and bus mode bank
`timescale 1ns/1ps
`include "wbm_cfg.svh"
module tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hwUpdate, watchdogResetEvent, watchdogTriggerGood, spiFailClear;
	logic [1:0] sysMode, canModeActive, firstLinModeActive, secondLinModeActive;
	logic [7:0] hwWdogValue, hwBus1Value, hwBus2Value, d, v;
	logic csN, sclk, mosi, misoO, misoOeN, spiFail, watchdogRun;
	logic windowStyleSelect, startOnBusWake, resetLimitEn, resetAllowed;
	logic periodReserved, linFlash, slowEdgeSelect, transmitStuckGuardEn;
	logic [2:0] guardPeriodSelect;
	logic [1:0] canCode;
	logic clkEn = 1'b1;
	integer seed, badCount = 0, nChecks = 0;
	// 25 MHz clock
	always #20 clk = ~clk;
	wbm_bank u_dut (.clk, .reset, .clkEn, .csN, .sclk, .mosi, .misoO,
		.misoOeN, .sysMode, .hwUpdate, .hwWdogValue, .hwBus1Value, .hwBus2Value,
		.watchdogResetEvent, .watchdogTriggerGood, .spiFail, .spiFailClear,
		.watchdogRun, .windowStyleSelect, .startOnBusWake, .resetLimitEn,
		.resetAllowed, .guardPeriodSelect, .periodReserved, .linFlash,
		.slowEdgeSelect, .transmitStuckGuardEn, .canModeActive,
		.firstLinModeActive, .secondLinModeActive);
	wbm_host u_host (.clk, .csN, .sclk, .mosi, .misoO, .misoOeN);
	task automatic chk(input string what, input logic [7:0] exp, got);
		nChecks++;
		if (got !== exp) begin
			badCount++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] dat);
		logic [7:0] r;
		u_host.xfer({dat, 1'b1, a}, 16, r);
	endtask
	// Read frames carry a full data byte that must never be written
	task automatic rd(input logic [6:0] a, output logic [7:0] r);
		u_host.xfer({8'hFF, 1'b0, a}, 16, r);
	endtask
	// One-cycle pulse of {hwUpdate, resetEvent, triggerGood, failClear}
	task automatic ev(input logic [3:0] p);
		{hwUpdate, watchdogResetEvent, watchdogTriggerGood, spiFailClear} = p;
		@(negedge clk);
		{hwUpdate, watchdogResetEvent, watchdogTriggerGood, spiFailClear} = 4'h0;
		@(negedge clk);
	endtask
	function automatic logic [1:0] act(input logic [1:0] c, m);
		return (c == 2'h3 && (m == 2'h1 || m == 2'h2)) ? 2'h1 : c;
	endfunction
	task automatic stopTest;
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (90000) @(posedge clk);
		badCount++;
		stopTest();
	end
	// Main sequence
	initial begin
		seed = 32'hE21C4A28;
		sysMode = 2'h0;
		{hwWdogValue, hwBus1Value, hwBus2Value} = 24'h000000;
		{hwUpdate, watchdogResetEvent, watchdogTriggerGood, spiFailClear} = 4'h0;
		repeat (4) @(negedge clk);
		reset = 1'b0;
		rd(`WBM_ADDR_WDOG, v);
		chk("wdog rst", `WBM_RST_WDOG, v);
		rd(`WBM_ADDR_BUS1, v);
		chk("bus1 rst", `WBM_RST_BUS1, v);
		rd(`WBM_ADDR_BUS2, v);
		chk("bus2 rst", `WBM_RST_BUS2, v);
		// First pass all ones, then random
		for (int i = 0; i < 6; i++) begin
			d = i ? 8'($random(seed)) : 8'hFF;
			wr(`WBM_ADDR_BUS1, d);
			rd(`WBM_ADDR_BUS1, v);
			chk("bus1", d & 8'hFB, v);
			chk("bus1 out", d & 8'hFB, {linFlash, slowEdgeSelect,
				transmitStuckGuardEn, firstLinModeActive, 1'b0,
				canModeActive});
			wr(`WBM_ADDR_BUS2, d);
			rd(`WBM_ADDR_BUS2, v);
			chk("bus2", d & 8'h03, v);
			chk("second_lin_mode", d & 8'h03, {6'h00, secondLinModeActive});
			d[7] = ^d[6:0];
			wr(`WBM_ADDR_WDOG, d);
			rd(`WBM_ADDR_WDOG, v);
			chk("wdog", d & 8'h7F, v);
			chk("wdog out", d & 8'h3F, {2'h0, windowStyleSelect, startOnBusWake,
				resetLimitEn, guardPeriodSelect});
			chk("per rsvd", {7'h00, d[2:1] == 2'h3}, {7'h00, periodReserved});
			wr(`WBM_ADDR_WDOG, d ^ 8'h01);
			rd(`WBM_ADDR_WDOG, v);
			chk("odd wdog", d & 8'h7F, v);
			chk("fail set", 8'h01, {7'h00, spiFail});
			ev(4'h1);
			chk("fail clr", 8'h00, {7'h00, spiFail});
		end
		// Normal transceivers fall back in low power, receive-only kept
		wr(`WBM_ADDR_BUS2, 8'h02);
		wr(`WBM_ADDR_WDOG, 8'hC0);
		for (int m = 0; m < 5; m++) begin
			// CAN must be wake capable before sleep is commanded
			canCode = (m == 1) ? 2'h1 : 2'h3;
			wr(`WBM_ADDR_BUS1, {6'h06, canCode});
			sysMode = 2'(m);
			rd(`WBM_ADDR_BUS1, v);
			chk("bus1 kept", {6'h06, canCode}, v);
			chk("can act", {6'h00, act(canCode, sysMode)},
				{6'h00, canModeActive});
			chk("lin act", {4'h0, act(2'h3, sysMode), 2'h2}, {4'h0,
				firstLinModeActive, secondLinModeActive});
			chk("wd run", {7'h00, sysMode != 2'h2}, {7'h00, watchdogRun});
		end
		// Frames one bit short or long are refused
		u_host.xfer({8'h03, 1'b1, `WBM_ADDR_BUS2}, 15, v);
		u_host.xfer({8'h03, 1'b1, `WBM_ADDR_BUS2}, 17, v);
		rd(`WBM_ADDR_BUS2, v);
		chk("bad len", 8'h02, v);
		// Reset limit on, then off
		wr(`WBM_ADDR_WDOG, 8'h88);
		for (int k = 0; k < 3; k++) begin
			chk("rst ok", 8'h01, {7'h00, resetAllowed});
			ev(4'h4);
		end
		chk("rst cut", 8'h00, {7'h00, resetAllowed});
		ev(4'h2);
		chk("rst back", 8'h01, {7'h00, resetAllowed});
		wr(`WBM_ADDR_WDOG, 8'h00);
		repeat (4) ev(4'h4);
		chk("no limit", 8'h01, {7'h00, resetAllowed});
		wr(7'h06, 8'hFF);
		rd(7'h06, v);
		chk("unmapped", 8'h00, v);
		// Hardware reaches only its own fields; host-only bits stay clear
		{hwWdogValue, hwBus1Value, hwBus2Value} =
			24'($random(seed)) | 24'hA8E485;
		// Low clock enable freezes the update
		clkEn = 1'b0;
		ev(4'h8);
		clkEn = 1'b1;
		rd(`WBM_ADDR_BUS2, v);
		chk("frozen", 8'h02, v);
		ev(4'h8);
		rd(`WBM_ADDR_WDOG, v);
		chk("hw wdog", hwWdogValue & 8'h57, v);
		rd(`WBM_ADDR_BUS1, v);
		chk("hw bus1", hwBus1Value & 8'h1B, v);
		rd(`WBM_ADDR_BUS2, v);
		chk("hw bus2", hwBus2Value & 8'h03, v);
		reset = 1'b1;
		@(negedge clk);
		reset = 1'b0;
		rd(`WBM_ADDR_BUS1, v);
		chk("bus1 rst2", `WBM_RST_BUS1, v);
		rd(`WBM_ADDR_WDOG, v);
		chk("wdog rst2", `WBM_RST_WDOG, v);
		stopTest();
	end
endmodule // tb_top
bind wbm_bank wbm_bank_assertions u_chk (.clk, .reset, .clkEn, .csN, .sysMode,
	.watchdogResetEvent, .watchdogTriggerGood, .spiFail, .spiFailClear,
	.watchdogRun, .resetLimitEn, .resetAllowed, .guardPeriodSelect,
	.periodReserved, .misoOeN, .canModeActive, .firstLinModeActive,
	.secondLinModeActive);
